// ===== hdl/kdr_map.svh
`ifndef KDR_MAP_SVH
`define KDR_MAP_SVH

// =====================================================================
// key scan timing, in oscillator periods
`define KDR_SCAN_PERIODS   4800
`define KDR_RESCAN_PERIODS 9600

// =====================================================================
// serial link layout
`define KDR_KEY_ADDR       8'h43
`define KDR_ADDR_BITS      8
`define KDR_FRAME_BITS     32
`define KDR_KEY_BITS       30
`define KDR_SLEEP_POS      30
`define KDR_LINK_HALF      4

// =====================================================================
// controller timing, in system clock cycles
`define KDR_XFER_CYCLES    ((`KDR_ADDR_BITS + `KDR_FRAME_BITS + 2) * 2 * `KDR_LINK_HALF)
`define KDR_POLL_CYCLES    (`KDR_RESCAN_PERIODS + `KDR_XFER_CYCLES + 256)
`define KDR_GUARD_CYCLES   (`KDR_RESCAN_PERIODS + 256)

`endif

// ===== hdl/kdr_pkg.sv
`default_nettype none
package kdr_pkg;

    // =================================================================
    // data types
    typedef logic [29:0] kdr_key_type;

    typedef enum logic [2:0] {
        KDR_SCAN_IDLE  = 3'b001,
        KDR_SCAN_RUN   = 3'b010,
        KDR_SCAN_READY = 3'b100
    } kdr_scan_state_type;

    typedef enum logic [5:0] {
        KDR_CTL_WAIT = 6'b000001,
        KDR_CTL_PREP = 6'b000010,
        KDR_CTL_ADDR = 6'b000100,
        KDR_CTL_CEUP = 6'b001000,
        KDR_CTL_READ = 6'b010000,
        KDR_CTL_FIN  = 6'b100000
    } kdr_ctl_state_type;

endpackage : kdr_pkg
`default_nettype wire

// ===== hdl/kdr_link_if.sv
`default_nettype none
interface kdr_link_if;

    // =================================================================
    // link wires
    logic ce;
    logic cl;
    logic di;
    logic doOut;
    logic doOe;
    logic doLine;

    // open-drain data output with pull-up
    assign doLine = doOe ? doOut : 1'b1;

    modport dev (
        input  ce,
        input  cl,
        input  di,
        output doOut,
        output doOe
    );

    modport ctl (
        output ce,
        output cl,
        output di,
        input  doLine
    );

endinterface : kdr_link_if
`default_nettype wire

// ===== hdl/kdr_key_ctl.sv
`include "kdr_map.svh"
`default_nettype none
module kdr_key_ctl #(
    parameter int HALF         = `KDR_LINK_HALF,
    parameter int POLL_CYCLES  = `KDR_POLL_CYCLES,
    parameter int GUARD_CYCLES = `KDR_GUARD_CYCLES
) (
    // link to the device
    kdr_link_if.ctl                   lnk,
    // clock and reset
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // mode: 0 timer polling, 1 interrupt style
    input  wire logic                 intMode,
    // read results
    output kdr_pkg::kdr_key_type      keyData,
    output logic                      sleepAckBit,
    output logic                      keyValid
);
    import kdr_pkg::*;

    localparam int WW = $clog2(((POLL_CYCLES > GUARD_CYCLES) ? POLL_CYCLES : GUARD_CYCLES) + 1);
    localparam logic [WW-1:0] POLL_LOAD  = WW'(POLL_CYCLES);
    localparam logic [WW-1:0] GUARD_LOAD = WW'(GUARD_CYCLES);
    localparam logic [7:0]    PH_HIGH    = 8'(HALF - 1);
    localparam logic [7:0]    PH_END     = 8'(2 * HALF - 1);
    localparam logic [5:0]    ADDR_LAST  = 6'(`KDR_ADDR_BITS - 1);
    localparam logic [5:0]    FRAME_LAST = 6'(`KDR_FRAME_BITS - 1);

    function automatic logic addrBit(input logic [5:0] idx);
        logic [7:0] a;
        a = `KDR_KEY_ADDR;
        return a[idx[2:0]];
    endfunction : addrBit

    // =================================================================
    // data output synchroniser
    logic doMeta;
    logic doSync;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            doMeta <= 1'b1;
            doSync <= 1'b1;
        end else begin
            doMeta <= lnk.doLine;
            doSync <= doMeta;
        end
    end

    // =================================================================
    // sequencer
    kdr_ctl_state_type state,     next_state;
    logic [7:0]        phase,     next_phase;
    logic [5:0]        bitCnt,    next_bitCnt;
    logic [WW-1:0]     waitCnt,   next_waitCnt;
    logic [31:0]       shiftIn,   next_shiftIn;
    logic              ce,        next_ce;
    logic              cl,        next_cl;
    logic              di,        next_di;
    kdr_key_type       next_keyData;
    logic              next_sleepAckBit;
    logic              next_keyValid;
    logic [7:0]        phaseInc;

    always_comb begin
        next_state       = state;
        next_phase       = phase;
        next_bitCnt      = bitCnt;
        next_waitCnt     = waitCnt;
        next_shiftIn     = shiftIn;
        next_ce          = ce;
        next_cl          = cl;
        next_di          = di;
        next_keyData     = keyData;
        next_sleepAckBit = sleepAckBit;
        next_keyValid    = 1'b0;
        phaseInc         = (phase == PH_END) ? 8'h00 : 8'(phase + 8'h01);
        case (state)
            KDR_CTL_WAIT: begin
                next_ce = 1'b0;
                next_cl = 1'b0;
                if (waitCnt != '0) begin
                    next_waitCnt = WW'(waitCnt - 1'b1);
                end else if (!doSync) begin
                    // only a low data output starts a read
                    next_state  = KDR_CTL_PREP;
                    next_bitCnt = 6'h00;
                    next_di     = addrBit(6'h00);
                end else if (!intMode) begin
                    next_waitCnt = POLL_LOAD;
                end
            end
            KDR_CTL_PREP: begin
                next_state = KDR_CTL_ADDR;
                next_phase = 8'h00;
                next_cl    = 1'b1;
            end
            KDR_CTL_ADDR: begin
                next_phase = phaseInc;
                if (phase == PH_HIGH) begin
                    next_cl = 1'b0;
                    // move data on the falling edge so it is settled at the next rise
                    if (bitCnt != ADDR_LAST) begin
                        next_di = addrBit(6'(bitCnt + 6'h01));
                    end
                end
                if (phase == PH_END) begin
                    if (bitCnt == ADDR_LAST) begin
                        next_state = KDR_CTL_CEUP;
                        next_ce    = 1'b1;
                        next_phase = 8'h00;
                    end else begin
                        next_bitCnt = 6'(bitCnt + 6'h01);
                        next_cl     = 1'b1;
                    end
                end
            end
            KDR_CTL_CEUP: begin
                next_phase = phaseInc;
                if (phase == PH_HIGH) begin
                    next_state  = KDR_CTL_READ;
                    next_phase  = 8'h00;
                    next_bitCnt = 6'h00;
                    next_cl     = 1'b1;
                end
            end
            KDR_CTL_READ: begin
                next_phase = phaseInc;
                if (phase == PH_HIGH) begin
                    next_cl = 1'b0;
                end
                if (phase == PH_END) begin
                    next_shiftIn = {doSync, shiftIn[31:1]};
                    if (bitCnt == FRAME_LAST) begin
                        next_state = KDR_CTL_FIN;
                        next_phase = 8'h00;
                    end else begin
                        next_bitCnt = 6'(bitCnt + 6'h01);
                        next_cl     = 1'b1;
                    end
                end
            end
            KDR_CTL_FIN: begin
                next_phase = phaseInc;
                if (phase == PH_HIGH) begin
                    next_state       = KDR_CTL_WAIT;
                    next_ce          = 1'b0;
                    next_keyData     = shiftIn[`KDR_KEY_BITS-1:0];
                    next_sleepAckBit = shiftIn[`KDR_SLEEP_POS];
                    next_keyValid    = 1'b1;
                    // guard (interrupt mode) or poll period (timer mode) before the next look at the output
                    next_waitCnt     = intMode ? GUARD_LOAD : POLL_LOAD;
                end
            end
            default: begin
                next_state = KDR_CTL_WAIT;
                next_ce    = 1'b0;
                next_cl    = 1'b0;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state       <= KDR_CTL_WAIT;
            phase       <= 8'h00;
            bitCnt      <= 6'h00;
            waitCnt     <= '0;
            shiftIn     <= 32'h0000_0000;
            ce          <= 1'b0;
            cl          <= 1'b0;
            di          <= 1'b0;
            keyData     <= '0;
            sleepAckBit <= 1'b0;
            keyValid    <= 1'b0;
        end else begin
            state       <= next_state;
            phase       <= next_phase;
            bitCnt      <= next_bitCnt;
            waitCnt     <= next_waitCnt;
            shiftIn     <= next_shiftIn;
            ce          <= next_ce;
            cl          <= next_cl;
            di          <= next_di;
            keyData     <= next_keyData;
            sleepAckBit <= next_sleepAckBit;
            keyValid    <= next_keyValid;
        end
    end

    assign lnk.ce = ce;
    assign lnk.cl = cl;
    assign lnk.di = di;

endmodule : kdr_key_ctl
`default_nettype wire

// ===== hdl/kdr_key_device.sv
// What this block does
// - matching double scan completes within 4800 periods
// - mismatching scans rescan, total 9600 periods
// - data output low while enable low, key ready
// - controller sends address 43h, then reads data
// - timer mode polls output every period, reads low
// - poll period exceeds rescan plus transfer times
// - reads with output high give invalid data
// - interrupt mode waits guard interval after read
// - guard interval exceeds rescan execution time
`include "kdr_map.svh"
`default_nettype none
module kdr_key_device #(
    parameter int SCAN_PERIODS = `KDR_SCAN_PERIODS
) (
    // link to the controller
    kdr_link_if.dev                   lnk,
    // oscillator domain
    input  wire logic                 sys_clk,
    input  wire logic                 rst,
    // key matrix and sleep state
    input  wire kdr_pkg::kdr_key_type keyIn,
    input  wire logic                 sleepAck,
    // status
    output logic                      keyReady,
    output logic                      scanBusy
);
    import kdr_pkg::*;

    localparam int            CW        = $clog2(SCAN_PERIODS + 1);
    localparam logic [CW-1:0] FIRST_END = CW'(SCAN_PERIODS / 2 - 1);
    localparam logic [CW-1:0] SCAN_END  = CW'(SCAN_PERIODS - 1);
    localparam logic [7:0]    KEY_ADDR  = `KDR_KEY_ADDR;
    localparam logic [5:0]    FRAME_LEN = 6'(`KDR_FRAME_BITS);

    function automatic logic anyKey(input kdr_key_type k);
        return |k;
    endfunction : anyKey

    // =================================================================
    // input synchronisers, oscillator domain
    kdr_key_type keyMeta;
    kdr_key_type keySync;
    logic        saMeta;
    logic        saSync;
    logic        ceMeta;
    logic        ceSync;
    logic        doneMeta;
    logic        doneSync;
    logic        doneGate;
    logic        doneGatePrev;
    logic        readDone;
    logic        frameDone;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            keyMeta      <= '0;
            keySync      <= '0;
            saMeta       <= 1'b0;
            saSync       <= 1'b0;
            ceMeta       <= 1'b0;
            ceSync       <= 1'b0;
            doneMeta     <= 1'b0;
            doneSync     <= 1'b0;
            doneGatePrev <= 1'b0;
        end else begin
            keyMeta      <= keyIn;
            keySync      <= keyMeta;
            saMeta       <= sleepAck;
            saSync       <= saMeta;
            ceMeta       <= lnk.ce;
            ceSync       <= ceMeta;
            doneMeta     <= frameDone;
            doneSync     <= doneMeta;
            doneGatePrev <= doneGate;
        end
    end

    // frame end only counts while enable is high, so stale link state
    // from before the first frame can never clear the ready flag
    assign doneGate = doneSync & ceSync;
    assign readDone = doneGate & ~doneGatePrev;

    // =================================================================
    // key scan, oscillator domain
    kdr_scan_state_type scanState, next_scanState;
    logic [CW-1:0]      scanCnt,   next_scanCnt;
    kdr_key_type        firstKeys, next_firstKeys;
    kdr_key_type        keyData,   next_keyData;
    logic               sleepData, next_sleepData;

    always_comb begin
        next_scanState = scanState;
        next_scanCnt   = scanCnt;
        next_firstKeys = firstKeys;
        next_keyData   = keyData;
        next_sleepData = sleepData;
        case (scanState)
            KDR_SCAN_IDLE: begin
                if (anyKey(keySync)) begin
                    next_scanState = KDR_SCAN_RUN;
                    next_scanCnt   = '0;
                end
            end
            KDR_SCAN_RUN: begin
                next_scanCnt = CW'(scanCnt + 1'b1);
                if (scanCnt == FIRST_END) begin
                    next_firstKeys = keySync;
                end
                if (scanCnt == SCAN_END) begin
                    if (keySync == firstKeys) begin
                        if (anyKey(keySync)) begin
                            next_scanState = KDR_SCAN_READY;
                            next_keyData   = keySync;
                            next_sleepData = saSync;
                        end else begin
                            next_scanState = KDR_SCAN_IDLE;
                        end
                    end else begin
                        // disagreeing scans: run the scan once more
                        next_scanCnt = '0;
                    end
                end
            end
            KDR_SCAN_READY: begin
                if (readDone) begin
                    next_scanState = KDR_SCAN_IDLE;
                end
            end
            default: begin
                next_scanState = KDR_SCAN_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            scanState <= KDR_SCAN_IDLE;
            scanCnt   <= '0;
            firstKeys <= '0;
            keyData   <= '0;
            sleepData <= 1'b0;
        end else begin
            scanState <= next_scanState;
            scanCnt   <= next_scanCnt;
            firstKeys <= next_firstKeys;
            keyData   <= next_keyData;
            sleepData <= next_sleepData;
        end
    end

    assign keyReady = (scanState == KDR_SCAN_READY);
    assign scanBusy = (scanState == KDR_SCAN_RUN);

    // =================================================================
    // serial side, link clock domain
    // keyData and sleepData are quasi-static: they change only on entry
    // to ready and hold until the read ends, so the word is taken whole;
    // a read outside ready returns stale, invalid data
    logic [7:0]  addrShift, next_addrShift;
    logic        matched,   next_matched;
    logic [5:0]  bitCnt,    next_bitCnt;
    logic [31:0] outShift,  next_outShift;
    logic        outBit,    next_outBit;
    logic        next_frameDone;
    logic [31:0] frame;

    always_comb begin
        frame          = {1'b0, sleepData, keyData};
        next_addrShift = addrShift;
        next_matched   = matched;
        next_bitCnt    = bitCnt;
        next_outShift  = outShift;
        next_outBit    = outBit;
        next_frameDone = frameDone;
        if (!lnk.ce) begin
            // address phase, lsb first
            next_addrShift = {lnk.di, addrShift[7:1]};
            next_bitCnt    = 6'h00;
            next_matched   = 1'b0;
            next_outBit    = 1'b1;
            next_frameDone = 1'b0;
        end else if (bitCnt == 6'h00) begin
            next_matched  = (addrShift == KEY_ADDR);
            next_outBit   = frame[0];
            next_outShift = {1'b0, frame[31:1]};
            next_bitCnt   = 6'h01;
        end else if (bitCnt != FRAME_LEN) begin
            next_outBit   = outShift[0];
            next_outShift = {1'b0, outShift[31:1]};
            next_bitCnt   = 6'(bitCnt + 6'h01);
            if (bitCnt == 6'(FRAME_LEN - 6'h01)) begin
                next_frameDone = matched;
            end
        end else begin
            next_outBit = 1'b1;
        end
    end

    always_ff @(posedge lnk.cl) begin
        addrShift <= next_addrShift;
        matched   <= next_matched;
        bitCnt    <= next_bitCnt;
        outShift  <= next_outShift;
        outBit    <= next_outBit;
        frameDone <= next_frameDone;
    end

    // =================================================================
    // open-drain data output
    assign lnk.doOut = 1'b0;
    // enable low: pull low while a confirmed key waits
    // enable high: shift the frame out, only after our address
    assign lnk.doOe  = lnk.ce ? (matched & ~outBit) : keyReady;

endmodule : kdr_key_device
`default_nettype wire

// ===== tb/kdr_key_asserts.sv
`default_nettype none
module kdr_key_asserts #(
    parameter int SCAN  = 48,
    parameter int POLL  = 1000,
    parameter int GUARD = 600
) (
    // clocks and reset
    input wire logic sys_clk,
    input wire logic oscClk,
    input wire logic rst,
    // link wires
    input wire logic ce,
    input wire logic cl,
    input wire logic di,
    input wire logic doOut,
    input wire logic doOe,
    input wire logic doLine,
    // status
    input wire logic keyReady,
    input wire logic scanBusy,
    input wire logic keyValid,
    input wire logic intMode
);

    // ====================================================
    // helper counters
    logic [15:0] scanCnt;
    logic [15:0] idleCnt;
    logic [7:0]  addrShift;
    logic [5:0]  dataRise;
    logic [3:0]  addrRise;
    logic [3:0]  lowAge;
    logic        clPrev;
    logic        clRise;

    assign clRise = cl && !clPrev;

    always_ff @(posedge oscClk) begin
        scanCnt <= (rst || !scanBusy) ? 16'h0 : scanCnt + 16'h1;
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            clPrev    <= 1'b0;
            addrRise  <= 4'h0;
            addrShift <= 8'h0;
            dataRise  <= 6'h0;
            lowAge    <= 4'hf;
            idleCnt   <= 16'hffff;
        end else begin
            clPrev <= cl;
            // address bits arrive lsb first while enable is low
            if (ce) begin
                addrRise <= 4'h0;
            end else if (clRise) begin
                addrRise  <= addrRise + 4'h1;
                addrShift <= {di, addrShift[7:1]};
            end
            if (!ce) begin
                dataRise <= 6'h0;
            end else if (clRise) begin
                dataRise <= dataRise + 6'h1;
            end
            lowAge  <= !doLine ? 4'h0 : (lowAge == 4'hf ? lowAge : lowAge + 4'h1);
            idleCnt <= keyValid ? 16'h0 : (idleCnt == 16'hffff ? idleCnt : idleCnt + 16'h1);
        end
    end

    // ====================================================
    // device side
    chk_ready_pulls_low: assert property (@(posedge oscClk) disable iff (rst)
        keyReady && $past(keyReady, 2) && !ce |-> doOe && !doOut)
        else $error("ready key not signalled");
    chk_idle_released: assert property (@(posedge oscClk) disable iff (rst)
        !ce && !keyReady && !$past(keyReady) |-> !doOe)
        else $error("data line held without key");
    chk_oe_needs_ready: assert property (@(posedge oscClk) disable iff (rst)
        doOe |-> keyReady || $past(keyReady))
        else $error("line driven with no ready data");
    chk_scan_time: assert property (@(posedge oscClk) disable iff (rst)
        $rose(keyReady) |-> (scanCnt == SCAN || scanCnt == 2 * SCAN))
        else $error("scan time off");

    // ====================================================
    // controller side
    chk_addr_frame: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(ce) |-> addrRise == 4'h8 && addrShift == 8'h43)
        else $error("address phase wrong");
    chk_data_frame: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(ce) |-> dataRise == 6'h20 && !cl)
        else $error("data phase length wrong");
    chk_read_needs_low: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cl) && !ce && addrRise == 4'h0 |-> lowAge < 4'h8)
        else $error("read started with line high");
    chk_poll_guard_wait: assert property (@(posedge sys_clk) disable iff (rst)
        $rose(cl) && !ce && addrRise == 4'h0 |-> idleCnt >= (intMode ? GUARD : POLL))
        else $error("read started too early");
    chk_valid_pulse: assert property (@(posedge sys_clk) disable iff (rst)
        keyValid |-> !ce ##1 !keyValid)
        else $error("result pulse wrong");

    // ====================================================
    // scenario coverage
    cov_rescan: cover property (@(posedge oscClk) $rose(keyReady) && scanCnt == 2 * SCAN);
    cov_timer_read: cover property (@(posedge sys_clk) keyValid && !intMode);
    cov_intr_read: cover property (@(posedge sys_clk) keyValid && intMode);

endmodule : kdr_key_asserts
`default_nettype wire

// ===== tb/key_data_read_handshake_tb_top.sv
`default_nettype none
module key_data_read_handshake_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import kdr_pkg::*;

    localparam int SCAN  = 48;
    localparam int POLL  = 1000;
    localparam int GUARD = 600;
    localparam int LIMIT = 20000;

    logic        sys_clk;
    logic        oscClk;
    logic        rst;
    logic        intMode;
    logic        sleepAck;
    logic        keyReady;
    logic        scanBusy;
    logic        sleepAckBit;
    logic        keyValid;
    kdr_key_type keyIn;
    kdr_key_type keyData;
    int          miscompares = 0;
    int          compares    = 0;
    int          cycles      = 0;

    kdr_link_if lnk ();

    kdr_key_device #(.SCAN_PERIODS(SCAN)) kdr_key_device_inst (
        .lnk(lnk.dev), .sys_clk(oscClk), .rst(rst), .keyIn(keyIn),
        .sleepAck(sleepAck), .keyReady(keyReady), .scanBusy(scanBusy));

    kdr_key_ctl #(.HALF(4), .POLL_CYCLES(POLL), .GUARD_CYCLES(GUARD)) kdr_key_ctl_inst (
        .lnk(lnk.ctl), .sys_clk(sys_clk), .rst(rst), .intMode(intMode),
        .keyData(keyData), .sleepAckBit(sleepAckBit), .keyValid(keyValid));

    kdr_key_asserts #(.SCAN(SCAN), .POLL(POLL), .GUARD(GUARD)) kdr_key_asserts_inst (
        .sys_clk(sys_clk), .oscClk(oscClk), .rst(rst), .ce(lnk.ce), .cl(lnk.cl),
        .di(lnk.di), .doOut(lnk.doOut), .doOe(lnk.doOe), .doLine(lnk.doLine),
        .keyReady(keyReady), .scanBusy(scanBusy), .keyValid(keyValid), .intMode(intMode));

    // ====================================================
    // clocks and watchdog
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    initial begin
        oscClk = 1'b0;
        #7;
        forever #24 oscClk = ~oscClk;
    end

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == LIMIT) begin
            miscompares++;
            $display("ERROR %0t run did not finish", $time);
            end_of_test();
        end
    end

    // ====================================================
    // shared tasks
    task automatic end_of_test();
        if (miscompares == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : end_of_test

    task automatic expect_eq(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : expect_eq

    // counts oscillator periods from scan start to ready, optionally moving the key
    task automatic measure_scan(input int changeAt, input kdr_key_type newKey, output int n);
        n = 0;
        do begin
            @(posedge oscClk);
            #1;
        end while (scanBusy !== 1'b1);
        do begin
            @(posedge oscClk);
            #1;
            n++;
            if (n == changeAt) keyIn = newKey;
        end while (keyReady !== 1'b1);
    endtask : measure_scan

    task automatic wait_valid(output int waited);
        waited = 0;
        do begin
            @(posedge sys_clk);
            #1;
            waited++;
        end while (keyValid !== 1'b1);
    endtask : wait_valid

    // ====================================================
    // scenarios
    task automatic scen_confirmed_read();
        int n;
        int w;
        @(posedge sys_clk);
        #1;
        keyIn    = 30'h2aaa5555;
        sleepAck = 1'b1;
        measure_scan(0, 30'h0, n);
        expect_eq(n, SCAN, "agreed scan time");
        expect_eq({lnk.ce, lnk.doLine}, 2'b00, "ready not shown");
        keyIn = 30'h0;
        wait_valid(w);
        expect_eq(keyData, 30'h2aaa5555, "key bits");
        expect_eq(sleepAckBit, 1'b1, "sleep bit");
        repeat (60) @(posedge sys_clk);
        #1;
        expect_eq({keyReady, lnk.doLine}, 2'b01, "line not released");
    endtask : scen_confirmed_read

    task automatic scen_rescan_read();
        int n;
        int w;
        keyIn    = 30'h0000001;
        sleepAck = 1'b0;
        measure_scan(30, 30'h20000000, n);
        expect_eq(n, 2 * SCAN, "rescan time");
        keyIn = 30'h0;
        wait_valid(w);
        expect_eq(keyData, 30'h20000000, "polled key bits");
        expect_eq(sleepAckBit, 1'b0, "polled sleep bit");
        repeat (60) @(posedge sys_clk);
        #1;
    endtask : scen_rescan_read

    task automatic scen_interrupt_read();
        int n;
        int w;
        intMode  = 1'b1;
        keyIn    = 30'h12345678;
        sleepAck = 1'b1;
        measure_scan(0, 30'h0, n);
        expect_eq(n, SCAN, "interrupt scan time");
        wait_valid(w);
        expect_eq(keyData, 30'h12345678, "interrupt key bits");
        // key stays held, so a fresh scan is ready long before the guard ends
        wait_valid(w);
        expect_eq(w >= GUARD, 1'b1, "guard interval short");
        expect_eq(keyData, 30'h12345678, "second key bits");
        keyIn = 30'h0;
    endtask : scen_interrupt_read

    initial begin
        rst      = 1'b1;
        intMode  = 1'b0;
        keyIn    = 30'h0;
        sleepAck = 1'b0;
        repeat (16) @(posedge sys_clk);
        #1;
        rst = 1'b0;
        scen_confirmed_read();
        scen_rescan_read();
        scen_interrupt_read();
        end_of_test();
    end

endmodule : key_data_read_handshake_tb_top
`default_nettype wire
